/* logic/bcb_pkg.sv */
package bcb_pkg;

    // ------------------------------------------------------------
    // operation codes presented on op_i
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        BCB_OP_NONE = 4'h0,
        BCB_OP_XOR_BIT = 4'h1,
        BCB_OP_XOR_INV_BIT = 4'h2,
        BCB_OP_LOAD_BIT = 4'h3,
        BCB_OP_LOAD_INV_BIT = 4'h4,
        BCB_OP_STORE_BIT = 4'h5,
        BCB_OP_STORE_INV_BIT = 4'h6,
        BCB_OP_BRANCH = 4'h7,
        BCB_OP_JUMP = 4'h8,
        BCB_OP_CALL_REL = 4'h9,
        BCB_OP_CALL_ABS = 4'hA,
        BCB_OP_RETURN = 4'hB
    } bcb_op_t;

    // ------------------------------------------------------------
    // branch condition field encodings
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        BCB_CC_ALWAYS = 4'h0,
        BCB_CC_NEVER = 4'h1,
        BCB_CC_HIGH = 4'h2,
        BCB_CC_LOW_SAME = 4'h3,
        BCB_CC_CARRY_CLR = 4'h4,
        BCB_CC_CARRY_SET = 4'h5,
        BCB_CC_NOT_EQUAL = 4'h6,
        BCB_CC_EQUAL = 4'h7,
        BCB_CC_OVF_CLR = 4'h8,
        BCB_CC_OVF_SET = 4'h9,
        BCB_CC_PLUS = 4'hA,
        BCB_CC_MINUS = 4'hB,
        BCB_CC_GE = 4'hC,
        BCB_CC_LT = 4'hD,
        BCB_CC_GT = 4'hE,
        BCB_CC_LE = 4'hF
    } bcb_cc_t;

    // operand addressing modes usable by bit instructions
    typedef enum logic [1:0] {
        BCB_EA_REG = 2'h0,
        BCB_EA_REG_IND = 2'h1,
        BCB_EA_ABS = 2'h2,
        BCB_EA_BAD = 2'h3
    } bcb_ea_t;

    localparam int BCB_PC_W = 24;
    localparam int BCB_INSN_BYTES = 2;
    localparam int BCB_STACK_DEPTH = 16;
    localparam logic [23:0] BCB_PC_RESET = 24'h000000;
    localparam logic BCB_CARRY_RESET = 1'b0;

endpackage : bcb_pkg

/* logic/bcb_ret_stack.sv */
`timescale 1ns/10ps
// return address memory; read data registered
module bcb_ret_stack #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic wr_i,
    input wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    // refuse geometry the addressing cannot serve; a wrapping pointer needs a power-of-two depth
    if (DEPTH < 2 || WIDTH < 1 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_geometry
        $error("bcb_ret_stack: bad geometry");
    end

    // ------------------------------------------------------------
    // write port and registered read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (wr_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule : bcb_ret_stack

/* logic/bcb_exec.sv */
`timescale 1ns/10ps
// How it works
// - xor with bit sets carry to carry xor the chosen operand bit, operand untouched.
// - inverted xor sets carry to carry xor the complement of the chosen bit.
// - inverted xor, load and store take the bit position only from the 3-bit immediate.
// - load bit copies the chosen bit into carry and no other flag changes.
// - inverted load writes the complement of the chosen bit into carry.
// - store carry writes carry into the chosen bit and keeps the other seven bits.
// - inverted store writes inverted carry into the chosen bit and keeps the rest.
// - a conditional branch loads the target only when its condition holds, always and never included.
// - high, low-or-same, carry clear/set and not-equal/equal test carry and zero as listed.
// - overflow, sign, signed compare conditions test v, n, n xor v and z or (n xor v).
// - return loads the address saved by the latest call.
// - bit operands use register direct, register indirect or absolute addressing only.
module bcb_exec
    import bcb_pkg::*;
#(
    parameter int PC_W = bcb_pkg::BCB_PC_W,
    parameter int STACK_DEPTH = bcb_pkg::BCB_STACK_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic valid_i,
    input wire bcb_pkg::bcb_op_t op_i,
    input wire bcb_pkg::bcb_cc_t cc_i,
    input wire bcb_pkg::bcb_ea_t ea_mode_i,
    input wire logic [2:0] bit_imm_i,
    input wire logic [2:0] bit_reg_i,
    input wire logic [7:0] operand_i,
    input wire logic [PC_W-1:0] target_i,
    input wire logic flag_z_i,
    input wire logic flag_v_i,
    input wire logic flag_n_i,
    output logic carry_o,
    output logic carry_we_o,
    output logic [7:0] result_o,
    output logic result_we_o,
    output logic [PC_W-1:0] pc_o,
    output logic busy_o,
    output logic illegal_o
);
    import bcb_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    // elaboration checks; the stack pointer wraps, so depth must be a power of two
    if (PC_W < 8 || PC_W > 32) begin : g_bad_pc_w
        $error("bcb_exec: PC_W out of range");
    end
    if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("bcb_exec: STACK_DEPTH must be a power of two, at least 2");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // selected operand bit by 3-bit position
    function automatic logic pick_bit(input logic [7:0] b, input logic [2:0] pos);
        pick_bit = b[pos];
    endfunction : pick_bit

    // replace one bit, keep the other seven
    function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [2:0] pos, input logic v);
        logic [7:0] r;
        r = b;
        r[pos] = v;
        put_bit = r;
    endfunction : put_bit

    // branch condition evaluator
    function automatic logic cond_true(input bcb_cc_t cc, input logic c, input logic z,
                                       input logic v, input logic n);
        unique case (cc)
            BCB_CC_ALWAYS: cond_true = 1'b1;
            BCB_CC_NEVER: cond_true = 1'b0;
            BCB_CC_HIGH: cond_true = ~(c | z);
            BCB_CC_LOW_SAME: cond_true = c | z;
            BCB_CC_CARRY_CLR: cond_true = ~c;
            BCB_CC_CARRY_SET: cond_true = c;
            BCB_CC_NOT_EQUAL: cond_true = ~z;
            BCB_CC_EQUAL: cond_true = z;
            BCB_CC_OVF_CLR: cond_true = ~v;
            BCB_CC_OVF_SET: cond_true = v;
            BCB_CC_PLUS: cond_true = ~n;
            BCB_CC_MINUS: cond_true = n;
            BCB_CC_GE: cond_true = ~(n ^ v);
            BCB_CC_LT: cond_true = n ^ v;
            BCB_CC_GT: cond_true = ~(z | (n ^ v));
            BCB_CC_LE: cond_true = z | (n ^ v);
        endcase
    endfunction : cond_true

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic is_bit_op;
    logic ea_ok;
    logic bit_sel;
    logic [PC_W-1:0] next_seq_pc;
    logic [SP_W-1:0] sp;
    logic ret_wait;
    logic [PC_W-1:0] ret_addr;

    // inverted forms and the plain forms here all use the immediate; the
    // register bit number belongs to the set/clear/invert/test group only
    assign is_bit_op = (op_i inside {BCB_OP_XOR_BIT, BCB_OP_XOR_INV_BIT, BCB_OP_LOAD_BIT,
                                     BCB_OP_LOAD_INV_BIT, BCB_OP_STORE_BIT, BCB_OP_STORE_INV_BIT});
    assign ea_ok = (ea_mode_i != BCB_EA_BAD);
    assign bit_sel = pick_bit(operand_i, bit_imm_i);
    assign next_seq_pc = pc_o + PC_W'(BCB_INSN_BYTES);
    assign busy_o = ret_wait;

    // ------------------------------------------------------------
    // carry flag
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            carry_o <= BCB_CARRY_RESET;
            carry_we_o <= 1'b0;
        end else begin
            carry_we_o <= 1'b0;
            if (valid_i && !ret_wait && ea_ok) begin
                unique case (op_i)
                    BCB_OP_XOR_BIT: begin
                        carry_o <= carry_o ^ bit_sel;
                        carry_we_o <= 1'b1;
                    end
                    BCB_OP_XOR_INV_BIT: begin
                        carry_o <= carry_o ^ ~bit_sel;
                        carry_we_o <= 1'b1;
                    end
                    BCB_OP_LOAD_BIT: begin
                        carry_o <= bit_sel;
                        carry_we_o <= 1'b1;
                    end
                    BCB_OP_LOAD_INV_BIT: begin
                        carry_o <= ~bit_sel;
                        carry_we_o <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // byte write-back for the store forms
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_o <= 8'h00;
            result_we_o <= 1'b0;
        end else begin
            result_we_o <= 1'b0;
            if (valid_i && !ret_wait && ea_ok) begin
                if (op_i == BCB_OP_STORE_BIT) begin
                    result_o <= put_bit(operand_i, bit_imm_i, carry_o);
                    result_we_o <= 1'b1;
                end else if (op_i == BCB_OP_STORE_INV_BIT) begin
                    result_o <= put_bit(operand_i, bit_imm_i, ~carry_o);
                    result_we_o <= 1'b1;
                end else if (is_bit_op) begin
                    result_o <= operand_i; // xor/load leave the byte as it was
                end
            end
        end
    end

    // illegal addressing on a bit op is reported, not executed
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            illegal_o <= 1'b0;
        end else begin
            illegal_o <= valid_i && !ret_wait && is_bit_op && !ea_ok;
        end
    end

    // ------------------------------------------------------------
    // return stack pointer and memory
    // ------------------------------------------------------------
    logic push;
    logic pop;
    assign push = valid_i && !ret_wait && (op_i == BCB_OP_CALL_REL || op_i == BCB_OP_CALL_ABS);
    assign pop = valid_i && !ret_wait && (op_i == BCB_OP_RETURN);

    // pointer wraps on overflow; deep recursion overwrites the oldest entry
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sp <= '0;
        end else if (push) begin
            sp <= sp + SP_W'(1);
        end else if (pop) begin
            sp <= sp - SP_W'(1);
        end
    end

    bcb_ret_stack #(
        .WIDTH(PC_W),
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .clk_i(clk_i),
        .wr_i(push),
        .waddr_i(sp),
        .wdata_i(next_seq_pc),
        .raddr_i(sp - SP_W'(1)),
        .rdata_o(ret_addr)
    );

    // registered stack read costs one extra cycle on return
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ret_wait <= 1'b0;
        end else begin
            ret_wait <= pop;
        end
    end

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_o <= PC_W'(BCB_PC_RESET);
        end else if (ret_wait) begin
            pc_o <= ret_addr;
        end else if (valid_i) begin
            unique case (op_i)
                BCB_OP_BRANCH: begin
                    pc_o <= cond_true(cc_i, carry_o, flag_z_i, flag_v_i, flag_n_i) ? target_i : next_seq_pc;
                end
                BCB_OP_JUMP, BCB_OP_CALL_REL, BCB_OP_CALL_ABS: begin
                    pc_o <= target_i;
                end
                BCB_OP_RETURN: begin
                    pc_o <= pc_o; // wait for stacked address
                end
                default: begin
                    pc_o <= next_seq_pc;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_call;
        valid_i && !ret_wait && (op_i == BCB_OP_CALL_ABS || op_i == BCB_OP_CALL_REL);
    endsequence

    a_xor_carry: assert property (valid_i && !ret_wait && ea_ok && op_i == BCB_OP_XOR_BIT
        |=> carry_o == ($past(carry_o) ^ $past(operand_i[bit_imm_i])))
        else $error("xor carry wrong");
    a_xor_inv: assert property (valid_i && !ret_wait && ea_ok && op_i == BCB_OP_XOR_INV_BIT
        |=> carry_o == ($past(carry_o) ^ ~$past(operand_i[bit_imm_i])))
        else $error("inverted xor carry wrong");
    a_load_bit: assert property (valid_i && !ret_wait && ea_ok && op_i == BCB_OP_LOAD_BIT
        |=> carry_o == $past(operand_i[bit_imm_i]) && carry_we_o)
        else $error("load bit wrong");
    a_load_inv: assert property (valid_i && !ret_wait && ea_ok && op_i == BCB_OP_LOAD_INV_BIT
        |=> carry_o != $past(operand_i[bit_imm_i]))
        else $error("inverted load wrong");
    a_store_bit: assert property (valid_i && !ret_wait && ea_ok && op_i == BCB_OP_STORE_BIT
        |=> result_we_o && result_o[$past(bit_imm_i)] == $past(carry_o))
        else $error("store bit wrong");
    a_store_inv: assert property (valid_i && !ret_wait && ea_ok && op_i == BCB_OP_STORE_INV_BIT
        |=> result_we_o && result_o[$past(bit_imm_i)] != $past(carry_o))
        else $error("inverted store wrong");
    a_branch_never: assert property (valid_i && !ret_wait && op_i == BCB_OP_BRANCH && cc_i == BCB_CC_NEVER
        |=> pc_o == $past(pc_o) + PC_W'(BCB_INSN_BYTES))
        else $error("never branch taken");
    a_branch_eq: assert property (valid_i && !ret_wait && op_i == BCB_OP_BRANCH && cc_i == BCB_CC_EQUAL
        && flag_z_i |=> pc_o == $past(target_i))
        else $error("equal branch missed");
    a_branch_gt: assert property (valid_i && !ret_wait && op_i == BCB_OP_BRANCH && cc_i == BCB_CC_GT
        && (flag_n_i ^ flag_v_i) |=> pc_o != $past(target_i) || $past(target_i) == $past(next_seq_pc))
        else $error("greater branch wrongly taken");
    a_call_return: assert property (s_call ##1 (valid_i && op_i == BCB_OP_RETURN)
        |=> ##1 pc_o == $past(pc_o, 3) + PC_W'(BCB_INSN_BYTES))
        else $error("return address wrong");
    a_jump_target: assert property (valid_i && !ret_wait && op_i == BCB_OP_JUMP
        |=> pc_o == $past(target_i))
        else $error("jump target wrong");
    a_bad_ea: assert property (valid_i && !ret_wait && is_bit_op && !ea_ok
        |=> illegal_o && !carry_we_o && !result_we_o)
        else $error("bad addressing executed");
endmodule : bcb_exec

/* dv/tb.sv */
`timescale 1ns/10ps
module tb;
    import bcb_pkg::*;

    // ----------------------------------------
    // stimulus and model state
    // ----------------------------------------
    logic clk_i, rst_n_i, valid_i, flag_z_i, flag_v_i, flag_n_i;
    bcb_op_t op_i;
    bcb_cc_t cc_i;
    bcb_ea_t ea_mode_i;
    logic [2:0] bit_imm_i, bit_reg_i;
    logic [7:0] operand_i, result_o;
    logic [23:0] target_i, pc_o;
    logic carry_o, carry_we_o, result_we_o, busy_o, illegal_o;
    logic m_c;
    logic [7:0] m_res;
    logic [23:0] m_pc;
    logic [23:0] stk[$];
    int bad_count, compares;

    bcb_exec DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .valid_i(valid_i), .op_i(op_i), .cc_i(cc_i),
        .ea_mode_i(ea_mode_i), .bit_imm_i(bit_imm_i), .bit_reg_i(bit_reg_i), .operand_i(operand_i),
        .target_i(target_i), .flag_z_i(flag_z_i), .flag_v_i(flag_v_i), .flag_n_i(flag_n_i),
        .carry_o(carry_o), .carry_we_o(carry_we_o), .result_o(result_o), .result_we_o(result_we_o),
        .pc_o(pc_o), .busy_o(busy_o), .illegal_o(illegal_o));

    // 4 ns clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // reference condition evaluator, c is the model carry
    function automatic logic cond(input bcb_cc_t cc, input logic c, input logic z, input logic v, input logic n);
        case (cc)
            BCB_CC_ALWAYS: return 1'b1;
            BCB_CC_NEVER: return 1'b0;
            BCB_CC_HIGH: return !(c | z);
            BCB_CC_LOW_SAME: return c | z;
            BCB_CC_CARRY_CLR: return !c;
            BCB_CC_CARRY_SET: return c;
            BCB_CC_NOT_EQUAL: return !z;
            BCB_CC_EQUAL: return z;
            BCB_CC_OVF_CLR: return !v;
            BCB_CC_OVF_SET: return v;
            BCB_CC_PLUS: return !n;
            BCB_CC_MINUS: return n;
            BCB_CC_GE: return !(n ^ v);
            BCB_CC_LT: return n ^ v;
            BCB_CC_GT: return !(z | (n ^ v));
            default: return z | (n ^ v);
        endcase
    endfunction : cond

    // ----------------------------------------
    // one instruction: drive, model, compare
    // ----------------------------------------
    // valid_i stays high between calls, except after a return, so back-to-back issue is exercised
    task automatic issue(input bcb_op_t op, input bcb_cc_t cc, input bcb_ea_t ea, input logic [2:0] k,
                         input logic [23:0] tgt);
        logic [7:0] opd;
        logic b, wc, wr, il, z, v, n;
        logic [23:0] np;
        opd = 8'($urandom);
        {z, v, n} = 3'($urandom);
        valid_i = 1'b1;
        op_i = op;
        cc_i = cc;
        ea_mode_i = ea;
        bit_imm_i = k;
        bit_reg_i = ~k;
        operand_i = opd;
        target_i = tgt;
        {flag_z_i, flag_v_i, flag_n_i} = {z, v, n};
        @(posedge clk_i);
        b = opd[k];
        {wc, wr} = 2'b00;
        np = m_pc + 24'h000002;
        il = (op inside {[BCB_OP_XOR_BIT:BCB_OP_STORE_INV_BIT]}) && ea == BCB_EA_BAD;
        if (!il) begin
            case (op)
                BCB_OP_XOR_BIT: {m_c, wc} = {m_c ^ b, 1'b1};
                BCB_OP_XOR_INV_BIT: {m_c, wc} = {m_c ^ ~b, 1'b1};
                BCB_OP_LOAD_BIT: {m_c, wc} = {b, 1'b1};
                BCB_OP_LOAD_INV_BIT: {m_c, wc} = {~b, 1'b1};
                BCB_OP_STORE_BIT: {m_res, wr} = {(opd & ~(8'h01 << k)) | ({7'h00, m_c} << k), 1'b1};
                BCB_OP_STORE_INV_BIT: {m_res, wr} = {(opd & ~(8'h01 << k)) | ({7'h00, ~m_c} << k), 1'b1};
                BCB_OP_BRANCH: np = cond(cc, m_c, z, v, n) ? tgt : np;
                BCB_OP_JUMP: np = tgt;
                BCB_OP_CALL_REL, BCB_OP_CALL_ABS: begin
                    stk.push_back(np);
                    np = tgt;
                end
                default: ;
            endcase
        end
        #1;
        chk("carry", m_c, carry_o);
        chk("carry_we", wc, carry_we_o);
        chk("result_we", wr, result_we_o);
        if (wr) chk("result", m_res, result_o);
        chk("illegal", il, illegal_o);
        if (op == BCB_OP_RETURN) begin
            chk("busy", 1, busy_o);
            chk("pc hold", m_pc, pc_o);
            // a jump offered while busy must be dropped
            op_i = BCB_OP_JUMP;
            target_i = ~tgt;
            np = stk.pop_back();
            @(posedge clk_i);
            #1;
            valid_i = 1'b0;
        end
        chk("busy idle", 0, busy_o);
        m_pc = np;
        chk("pc", m_pc, pc_o);
        if (op == BCB_OP_RETURN) begin
            @(posedge clk_i);
            #1;
            chk("pc idle", m_pc, pc_o);
        end
    endtask : issue

    // hang guard well beyond the longest sequence
    initial begin
        #40000;
        bad_count++;
        $display("BAD watchdog expected done seen running");
        summarize();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {valid_i, flag_z_i, flag_v_i, flag_n_i, bit_imm_i, bit_reg_i} = '0;
        op_i = BCB_OP_NONE;
        cc_i = BCB_CC_ALWAYS;
        ea_mode_i = BCB_EA_REG;
        operand_i = 8'h00;
        target_i = 24'h000000;
        {m_c, m_res, m_pc} = '0;
        rst_n_i = 1'b0;
        void'($urandom(32'h3abf));
        repeat (12) @(posedge clk_i);
        chk("rst carry", 0, carry_o);
        chk("rst pc", 0, pc_o);
        chk("rst result", 0, result_o);
        chk("rst pulses", 0, {busy_o, carry_we_o, result_we_o, illegal_o});
        #1 rst_n_i = 1'b1;
        $display("test reset done");
        // every bit op at every position, then with the refused mode
        for (int o = 1; o <= 6; o++) begin
            for (int k = 0; k < 8; k++) begin
                issue(bcb_op_t'(o), BCB_CC_ALWAYS, bcb_ea_t'(k % 3), 3'(k), 24'h000000);
            end
            issue(bcb_op_t'(o), BCB_CC_ALWAYS, BCB_EA_BAD, 3'(o), 24'h000000);
        end
        $display("test bit_ops done");
        // carry set from a random bit, then each condition code with random flags
        for (int i = 0; i < 64; i++) begin
            issue(BCB_OP_LOAD_BIT, BCB_CC_ALWAYS, BCB_EA_ABS, 3'($urandom), 24'h000000);
            issue(BCB_OP_BRANCH, bcb_cc_t'(i % 16), BCB_EA_REG, 3'h0, 24'($urandom));
        end
        $display("test branches done");
        // full-depth nesting of both call kinds, then unwind
        for (int i = 0; i < 16; i++) begin
            issue(i % 2 ? BCB_OP_CALL_REL : BCB_OP_CALL_ABS, BCB_CC_ALWAYS, BCB_EA_REG, 3'h0, 24'($urandom));
        end
        issue(BCB_OP_JUMP, BCB_CC_NEVER, BCB_EA_REG, 3'h0, 24'($urandom));
        for (int i = 0; i < 16; i++) begin
            issue(BCB_OP_RETURN, BCB_CC_ALWAYS, BCB_EA_REG, 3'h0, 24'($urandom));
        end
        // a call followed at once by its return
        issue(BCB_OP_CALL_ABS, BCB_CC_ALWAYS, BCB_EA_REG, 3'h0, 24'($urandom));
        issue(BCB_OP_RETURN, BCB_CC_ALWAYS, BCB_EA_REG, 3'h0, 24'h000000);
        $display("test calls done");
        summarize();
    end
endmodule : tb
